// ### bar_decode_regs.vh
// Holds configuration offsets, field positions and default settings
// for the base window decode block. Assumes a 32-bit configuration
// data path addressed by dword index.
`ifndef BAR_DECODE_REGS_VH
`define BAR_DECODE_REGS_VH

// ****************************************************************
// Configuration dword indices
// ****************************************************************
`define CFG_IDX_VENDOR       6'h00
`define CFG_IDX_BASE0        6'h04
`define CFG_IDX_BASE5        6'h09
`define CFG_IDX_ROM          6'h0c

// ****************************************************************
// Field positions
// ****************************************************************
`define BASE_IO_BIT          0
`define BASE_TYPE_LO         1
`define BASE_TYPE_HI         2
`define BASE_TYPE_64         2'b10
`define ROM_ENABLE_BIT       0

// ****************************************************************
// Default settings
// ****************************************************************
`define BASE_SETTING_DEF     32'hfff00000
`define ROM_SETTING_DEF      32'hff000000
`define FIXED_BASE_DEF       32'hff000000
`define FIXED_ROM_DEF        32'hff000000
`define VENDOR_CODE_DEF      16'h0abc
`define WINDOW_COUNT_DEF     3'h1
`define HIGH_BITS_DEF        6'h08

`endif

// ### cfg_host_model.sv
// Host model: issues configuration and address cycles to the decode block.
// Assumes one clock shared with the block; drives 1 ns after each rising edge.
`timescale 1ns/1ps
module cfg_host_model
(
    input  wire        clock,
    output reg         cfg_wr,
    output reg         cfg_rd,
    output reg  [5:0]  cfg_idx,
    output reg  [31:0] cfg_wdata,
    output reg  [3:0]  cfg_be,
    input  wire [31:0] cfg_rdata_ff,
    input  wire        cfg_rvalid_ff,
    output reg         mem_space_en,
    output reg         addr_valid,
    output reg  [63:0] bus_addr,
    output reg         dual_addr,
    output reg         io_cycle,
    input  wire [5:0]  window_hit_ff,
    input  wire        rom_hit_ff,
    input  wire        claim_ff
);
    initial
    begin
        {cfg_wr, cfg_rd, addr_valid, dual_addr, io_cycle} = 5'h00;
        {cfg_idx, cfg_be, mem_space_en} = 11'h7f1;
        cfg_wdata = 32'h5a5a5a5a;
        bus_addr = 64'h0;
    end
    task wr(input [5:0] idx, input [31:0] d, input [3:0] be);
    begin
        @(posedge clock);
        #1;
        {cfg_wr, cfg_idx, cfg_wdata, cfg_be} = {1'b1, idx, d, be};
        @(posedge clock);
        #1;
        cfg_wr = 1'b0;
        // Released data must not look like it still holds
        cfg_wdata = ~d;
    end
    endtask
    task rd(input [5:0] idx, output [31:0] d, output late);
        integer n;
    begin
        @(posedge clock);
        #1;
        {cfg_rd, cfg_idx} = {1'b1, idx};
        @(posedge clock);
        #1;
        cfg_rd = 1'b0;
        late = 1'b1;
        n = 0;
        while (late && n < 4)
        begin
            if (cfg_rvalid_ff === 1'b1)
            begin
                d = cfg_rdata_ff;
                late = 1'b0;
            end
            else
            begin
                @(posedge clock);
                #1;
                n = n + 1;
            end
        end
    end
    endtask
    task probe(input [63:0] a, input d, input io, input en, output [7:0] res);
    begin
        @(posedge clock);
        #1;
        {addr_valid, bus_addr, dual_addr, io_cycle, mem_space_en} = {1'b1, a, d, io, en};
        @(posedge clock);
        #1;
        addr_valid = 1'b0;
        bus_addr = ~a;
        res = {rom_hit_ff, window_hit_ff, claim_ff};
    end
    endtask
endmodule // cfg_host_model

// ### pci_bar_config_decode.v
// Configuration identity and base window decode for a PCI target.
// Assumes the PCI core supplies decoded configuration accesses by
// dword index and the latched transaction address, all on the PCI clock.
`timescale 1ns/1ps
`include "bar_decode_regs.vh"

module pci_bar_config_decode
#(
    parameter [15:0]  vendor_code_setting  = `VENDOR_CODE_DEF, // Arbitrary value
    parameter [31:0]  base_setting_0       = `BASE_SETTING_DEF,
    parameter [31:0]  base_setting_1       = `BASE_SETTING_DEF,
    parameter [31:0]  base_setting_2       = `BASE_SETTING_DEF,
    parameter [31:0]  base_setting_3       = `BASE_SETTING_DEF,
    parameter [31:0]  base_setting_4       = `BASE_SETTING_DEF,
    parameter [31:0]  base_setting_5       = `BASE_SETTING_DEF,
    parameter [31:0]  rom_window_setting   = `ROM_SETTING_DEF,
    parameter [191:0] fixed_base_value     = {6{`FIXED_BASE_DEF}},
    parameter [5:0]   fixed_base_enable    = 6'h00,
    parameter [31:0]  fixed_rom_base_value = `FIXED_ROM_DEF,
    parameter         fixed_rom_base_enable = 1'b0,
    parameter [2:0]   window_count_setting = `WINDOW_COUNT_DEF,
    parameter [5:0]   high_rw_bits         = `HIGH_BITS_DEF
)
(
    input  wire        clock,
    input  wire        sys_rst,
    input  wire        cfg_wr,
    input  wire        cfg_rd,
    input  wire [5:0]  cfg_idx,
    input  wire [31:0] cfg_wdata,
    input  wire [3:0]  cfg_be,
    output reg  [31:0] cfg_rdata_ff,
    output reg         cfg_rvalid_ff,
    input  wire        mem_space_en,
    input  wire        addr_valid,
    input  wire [63:0] bus_addr,
    input  wire        dual_addr,
    input  wire        io_cycle,
    output reg  [5:0]  window_hit_ff,
    output reg         rom_hit_ff,
    output reg         claim_ff
);

    // ****************************************************************
    // Settings and helpers
    // ****************************************************************
    // Window zero in the lowest word
    localparam [191:0] settings = {base_setting_5, base_setting_4, base_setting_3,
                                   base_setting_2, base_setting_1, base_setting_0};

    function [31:0] setting_of;
        input [2:0] k;
        begin
            setting_of = settings[k*32 +: 32];
        end
    endfunction

    // Memory window carrying the 64-bit type code
    function is_64;
        input [2:0] k;
        begin
            is_64 = !settings[k*32 + `BASE_IO_BIT] &&
                    settings[k*32 + `BASE_TYPE_LO +: 2] == `BASE_TYPE_64;
        end
    endfunction

    // Upper word of a 64-bit pair decodes only the top high_rw_bits
    function [31:0] high_mask;
        input [5:0] n;
        begin
            high_mask = (n >= 6'h20) ? 32'hffffffff : ~(32'hffffffff >> n);
        end
    endfunction

    // Low flag bits of the window (space, type, prefetch) stay read-only
    function [31:0] addr_mask;
        input [31:0] s;
        begin
            addr_mask = s[`BASE_IO_BIT] ? (s & 32'hfffffffc) : (s & 32'hfffffff0);
        end
    endfunction

    // Low address word match under a compare mask
    function low_match;
        input [31:0] a;
        input [31:0] base;
        input [31:0] m;
        begin
            low_match = ((a & m) == (base & m));
        end
    endfunction

    // ****************************************************************
    // Pairing and presence
    // ****************************************************************
    // only windows 0 and 1, or else 1 and 2, may open a 64-bit pair
    localparam pair01 = (window_count_setting >= 3'h2) && is_64(3'h0);
    // Pair 0/1 wins, so window one is never both halves
    localparam pair12 = !pair01 && (window_count_setting >= 3'h3) && is_64(3'h1);

    // Absent windows get no writable bits and no compare
    // window present only below the configured count
    wire [5:0] present;
    genvar g;
    generate
        for (g = 0; g < 6; g = g + 1)
        begin : pres
            assign present[g] = (g < window_count_setting);
        end
    endgenerate

    // Upper half of a pair is a pure address word
    wire [5:0] is_upper = {3'h0, pair12, pair01, 1'b0};
    wire [5:0] is_lower = {4'h0, pair12, pair01};

    // Writable bits per window as seen on reads
    reg  [191:0] wmask;
    integer      k;
    always @*
    begin
        for (k = 0; k < 6; k = k + 1)
        begin
            if (!present[k])
                wmask[k*32 +: 32] = 32'h00000000;
            else if (is_upper[k])
                wmask[k*32 +: 32] = high_mask(high_rw_bits);
            else
                wmask[k*32 +: 32] = addr_mask(setting_of(k[2:0]));
        end
    end

    // ****************************************************************
    // Window storage
    // ****************************************************************
    // Dword indices 4 to 9 map to windows 0 to 5
    wire [31:0]  win_rd;
    wire [191:0] win_all;
    wire         win_wr = cfg_wr && cfg_idx >= `CFG_IDX_BASE0 && cfg_idx <= `CFG_IDX_BASE5;
    wire [2:0]   win_idx = cfg_idx[2:0] - 3'h4;

    window_regs #(
        .mask_bits (settings)
    ) u_windows (
        .clock      (clock),
        .sys_rst    (sys_rst),
        .wr_en      (win_wr),
        .wr_idx     (win_idx),
        .wr_data    (cfg_wdata),
        .wr_be      (cfg_be),
        .rd_idx     (win_idx),
        .rd_data_ff (win_rd),
        .all_ff     (win_all)
    );

    // Effective stored value: masked address bits plus read-only flags
    function [31:0] window_view;
        input [2:0] k;
        input [31:0] raw;
        input [31:0] m;
        begin
            if (is_upper[k])
                window_view = raw & m;
            else
                window_view = (raw & m) | (setting_of(k) & ~addr_mask(setting_of(k)));
        end
    endfunction

    // Absent windows read as zero whatever was written
    reg [191:0] eff;
    integer     e;
    always @*
    begin
        for (e = 0; e < 6; e = e + 1)
        begin
            if (!present[e])
                eff[e*32 +: 32] = 32'h00000000;
            else if (fixed_base_enable[e])
                eff[e*32 +: 32] = fixed_base_value[e*32 +: 32];
            else
                eff[e*32 +: 32] = window_view(e[2:0], win_all[e*32 +: 32],
                                              wmask[e*32 +: 32]);
        end
    end

    // ****************************************************************
    // Expansion ROM register
    // ****************************************************************
    reg [31:0] rom_ff;
    // Bit 0 is the decode enable, always writable
    wire [31:0] rom_mask = rom_window_setting | 32'h00000001;
    integer b;
    always @(posedge clock)
    begin
        if (sys_rst)
            rom_ff <= 32'h00000000;
        else if (cfg_wr && cfg_idx == `CFG_IDX_ROM)
        begin
            for (b = 0; b < 4; b = b + 1)
                if (cfg_be[b])
                    rom_ff[b*8 +: 8] <= cfg_wdata[b*8 +: 8] & rom_mask[b*8 +: 8];
        end
    end

    // fixed value only when its enable is set
    wire [31:0] rom_view = fixed_rom_base_enable ?
                           ((fixed_rom_base_value & 32'hfffffffe) | {31'h0, rom_ff[0]}) :
                           rom_ff;

    // ****************************************************************
    // Configuration reads
    // ****************************************************************
    // Window reads wait one cycle for the storage read register
    // Other indices are latched on the taking edge
    // Unknown indices answer zero rather than stall the host
    reg        rd_win_ff;
    reg [2:0]  rd_idx_ff;
    reg        rd_pend_ff;
    reg [31:0] rd_other_ff;
    always @(posedge clock)
    begin
        if (sys_rst)
        begin
            rd_win_ff     <= 1'b0;
            rd_idx_ff     <= 3'h0;
            rd_pend_ff    <= 1'b0;
            rd_other_ff   <= 32'h00000000;
            cfg_rdata_ff  <= 32'h00000000;
            cfg_rvalid_ff <= 1'b0;
        end
        else
        begin
            rd_pend_ff <= cfg_rd;
            rd_win_ff  <= cfg_rd && cfg_idx >= `CFG_IDX_BASE0 && cfg_idx <= `CFG_IDX_BASE5;
            rd_idx_ff  <= win_idx;
            if (cfg_idx == `CFG_IDX_VENDOR)
                rd_other_ff <= {16'h0000, vendor_code_setting};
            else if (cfg_idx == `CFG_IDX_ROM)
                rd_other_ff <= rom_view;
            else
                rd_other_ff <= 32'h00000000;
            cfg_rvalid_ff <= rd_pend_ff;
            if (rd_pend_ff)
                cfg_rdata_ff <= rd_win_ff ? eff_sel(rd_idx_ff, win_rd) : rd_other_ff;
        end
    end

    // Fixed windows bypass the stored read data
    function [31:0] eff_sel;
        input [2:0]  k;
        input [31:0] raw;
        begin
            if (k > 3'h5 || !present[k])
                eff_sel = 32'h00000000;
            else if (fixed_base_enable[k])
                eff_sel = fixed_base_value[k*32 +: 32];
            else
                eff_sel = window_view(k, raw, wmask[k*32 +: 32]);
        end
    endfunction

    // ****************************************************************
    // Address hit decode
    // ****************************************************************
    reg [5:0]  hit;
    reg [31:0] cmp_mask;
    reg [31:0] hi_word;
    integer    h;
    always @*
    begin
        cmp_mask = 32'h00000000;
        hi_word  = 32'h00000000;
        for (h = 0; h < 6; h = h + 1)
        begin
            // compared width and space from the setting
            cmp_mask = addr_mask(setting_of(h[2:0]));
            if (!present[h] || is_upper[h])
                hit[h] = 1'b0;
            else if (settings[h*32 + `BASE_IO_BIT])
                hit[h] = io_cycle &&
                    low_match(bus_addr[31:0], eff[h*32 +: 32], cmp_mask);
            else if (is_lower[h])
            begin
                // low word here, high in next
                hi_word = eff[(h+1)*32 +: 32] & high_mask(high_rw_bits);
                hit[h] = !io_cycle && mem_space_en &&
                    low_match(bus_addr[31:0], eff[h*32 +: 32], cmp_mask) &&
                    ((dual_addr ? bus_addr[63:32] & high_mask(high_rw_bits) :
                                  32'h00000000) == hi_word);
            end
            else
                hit[h] = !io_cycle && mem_space_en && !dual_addr &&
                    low_match(bus_addr[31:0], eff[h*32 +: 32], cmp_mask);
        end
    end

    // ROM decodes only with its fixed enable
    // Compare stops at bit 11 so a small setting cannot split a ROM block
    localparam [31:0] rom_cmp = rom_window_setting & 32'hfffff800;
    wire rom_hit = fixed_rom_base_enable && rom_view[`ROM_ENABLE_BIT] && mem_space_en &&
                   !io_cycle && !dual_addr &&
                   (((bus_addr[31:0] ^ fixed_rom_base_value) & rom_cmp) == 32'h00000000);

    // ****************************************************************
    // Registered hit outputs
    // ****************************************************************
    // One-cycle answer per address cycle, free of compare glitches
    always @(posedge clock)
    begin
        if (sys_rst)
        begin
            window_hit_ff <= 6'h00;
            rom_hit_ff    <= 1'b0;
            claim_ff      <= 1'b0;
        end
        else
        begin
            window_hit_ff <= addr_valid ? hit : 6'h00;
            rom_hit_ff    <= addr_valid && rom_hit;
            claim_ff      <= addr_valid && (|hit || rom_hit);
        end
    end

endmodule // pci_bar_config_decode

// ### pci_bar_config_decode_checker.sv
// Checker of the decode block's port timing and hit rules.
// Assumes it is bound to the top module and sees only its ports.
`timescale 1ns/1ps
module pci_bar_config_decode_checker
#(
    parameter [2:0]   window_count_setting  = 3'h1,
    parameter [31:0]  base_setting_2        = 32'hfff00000,
    parameter [191:0] fixed_base_value      = 192'h0,
    parameter [5:0]   fixed_base_enable     = 6'h00,
    parameter [31:0]  fixed_rom_base_value  = 32'hff000000,
    parameter         fixed_rom_base_enable = 1'b0,
    parameter [31:0]  rom_window_setting    = 32'hff000000
)
(
    input wire        clock,
    input wire        sys_rst,
    input wire        cfg_wr,
    input wire        cfg_rd,
    input wire [5:0]  cfg_idx,
    input wire [31:0] cfg_wdata,
    input wire [3:0]  cfg_be,
    input wire [31:0] cfg_rdata_ff,
    input wire        cfg_rvalid_ff,
    input wire        mem_space_en,
    input wire        addr_valid,
    input wire [63:0] bus_addr,
    input wire        dual_addr,
    input wire        io_cycle,
    input wire [5:0]  window_hit_ff,
    input wire        rom_hit_ff,
    input wire        claim_ff
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (sys_rst);
    property p_rd_lat; cfg_rd |-> ##2 cfg_rvalid_ff; endproperty
    a_rd_lat: assert property (p_rd_lat)
        else $error("read answer late");
    property p_rd_cause; cfg_rvalid_ff |-> $past(cfg_rd, 2); endproperty
    a_rd_cause: assert property (p_rd_cause)
        else $error("read answer without request");
    property p_claim_any; claim_ff == ((|window_hit_ff) || rom_hit_ff); endproperty
    a_claim_any: assert property (p_claim_any)
        else $error("claim disagrees with hits");
    property p_hit_cause; claim_ff |-> $past(addr_valid); endproperty
    a_hit_cause: assert property (p_hit_cause)
        else $error("claim without address");
    property p_mem_off; addr_valid && !mem_space_en && !io_cycle |=> !claim_ff; endproperty
    a_mem_off: assert property (p_mem_off)
        else $error("claim with memory space off");
    property p_absent; (window_hit_ff >> window_count_setting) == 6'h00; endproperty
    a_absent: assert property (p_absent)
        else $error("hit on absent window");
    property p_fix2;
        window_hit_ff[2] && fixed_base_enable[2] |->
            ((($past(bus_addr[31:0]) ^ fixed_base_value[95:64]) & base_setting_2
              & 32'hfffffff0) == 32'h0);
    endproperty
    a_fix2: assert property (p_fix2)
        else $error("fixed window hit on wrong address");
    property p_rom;
        rom_hit_ff |-> fixed_rom_base_enable &&
            ((($past(bus_addr[31:0]) ^ fixed_rom_base_value) & rom_window_setting) == 32'h0);
    endproperty
    a_rom: assert property (p_rom)
        else $error("rom hit on wrong address");
    property p_rst_quiet; disable iff (1'b0) sys_rst |=> !cfg_rvalid_ff && !claim_ff; endproperty
    a_rst_quiet: assert property (p_rst_quiet)
        else $error("output active after reset");
endmodule // pci_bar_config_decode_checker
bind pci_bar_config_decode pci_bar_config_decode_checker #(
    .window_count_setting(window_count_setting), .base_setting_2(base_setting_2),
    .fixed_base_value(fixed_base_value), .fixed_base_enable(fixed_base_enable),
    .fixed_rom_base_value(fixed_rom_base_value), .rom_window_setting(rom_window_setting),
    .fixed_rom_base_enable(fixed_rom_base_enable)) checker_i (.*);

// ### pci_bar_config_decode_tb.sv
// Testbench: configuration reads and writes plus address probes.
// Assumes the host model drives every input of the decode block except clock and sys_rst.
`timescale 1ns/1ps
`include "bar_decode_regs.vh"
module pci_bar_config_decode_tb;
    reg         clock = 1'b0;
    reg         sys_rst = 1'b1;
    wire        cfg_wr, cfg_rd, cfg_rvalid_ff, mem_space_en, addr_valid;
    wire        dual_addr, io_cycle, rom_hit_ff, claim_ff;
    wire [5:0]  cfg_idx, window_hit_ff;
    wire [31:0] cfg_wdata, cfg_rdata_ff;
    wire [3:0]  cfg_be;
    wire [63:0] bus_addr;
    integer     failures = 0;
    integer     samples_checked = 0;
    always #10 clock = ~clock;
    // Vendor code and fixed ROM base stay at their defaults
    pci_bar_config_decode #(.base_setting_0(32'hfff00004),
        .fixed_base_value({96'h0, 32'h40000000, 64'h0}), .fixed_base_enable(6'h04),
        .fixed_rom_base_enable(1'b1), .window_count_setting(3'h3)) pci_bar_config_decode_i (.*);
    cfg_host_model cfg_host_model_i (.*);
    task give_verdict;
    begin
        if (failures == 0 && samples_checked > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    end
    endtask
    task check(input [31:0] seen, input [31:0] exp);
    begin
        samples_checked = samples_checked + 1;
        if (seen !== exp)
        begin
            failures = failures + 1;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    end
    endtask
    task rd(input [5:0] idx, input [31:0] exp);
        reg [31:0] d;
        reg        late;
    begin
        cfg_host_model_i.rd(idx, d, late);
        if (late)
        begin
            failures = failures + 1;
            give_verdict;
        end
        else
            check(d, exp);
    end
    endtask
    task pr(input [63:0] a, input d, input io, input en, input [7:0] exp);
        reg [7:0] res;
    begin
        cfg_host_model_i.probe(a, d, io, en, res);
        check({24'h0, res}, {24'h0, exp});
    end
    endtask
    // ****************************************************************
    // Main sequence
    // ****************************************************************
    initial
    begin
        repeat (16) @(posedge clock);
        #1;
        sys_rst = 1'b0;
        rd(6'h00, {16'h0000, `VENDOR_CODE_DEF});
        cfg_host_model_i.wr(6'h00, 32'hffffffff, 4'hf);
        rd(6'h00, {16'h0000, `VENDOR_CODE_DEF});
        rd(6'h04, 32'h00000004);
        cfg_host_model_i.wr(6'h04, 32'h12345678, 4'hf);
        rd(6'h04, 32'h12300004);
        cfg_host_model_i.wr(6'h05, 32'h05000000, 4'hf);
        // Lanes off: the stored value must survive
        cfg_host_model_i.wr(6'h05, 32'hff000000, 4'h0);
        rd(6'h05, 32'h05000000);
        cfg_host_model_i.wr(6'h06, 32'h11100000, 4'hf);
        rd(6'h06, 32'h40000000);
        rd(6'h07, 32'h0);
        rd(6'h3f, 32'h0);
        rd(6'h0c, `FIXED_ROM_DEF);
        // ROM enable bit still clear: no decode yet
        pr({32'h0, (`FIXED_ROM_DEF | 32'h00000100)}, 1'b0, 1'b0, 1'b1, 8'h00);
        cfg_host_model_i.wr(6'h0c, 32'h00000001, 4'h1);
        rd(6'h0c, (`FIXED_ROM_DEF | 32'h00000001));
        pr({32'h05000000, 32'h12345678}, 1'b1, 1'b0, 1'b1, 8'h03);
        pr({32'h0, 32'h12345678}, 1'b0, 1'b0, 1'b1, 8'h00);
        pr({32'h0, 32'h40000abc}, 1'b0, 1'b0, 1'b1, 8'h09);
        pr({32'h0, 32'h40100000}, 1'b0, 1'b0, 1'b1, 8'h00);
        pr({32'h0, 32'h40000abc}, 1'b0, 1'b1, 1'b1, 8'h00);
        pr({32'h0, 32'h40000abc}, 1'b0, 1'b0, 1'b0, 8'h00);
        pr({32'h0, (`FIXED_ROM_DEF | 32'h00000100)}, 1'b0, 1'b0, 1'b1, 8'h81);
        pr({32'h0, (`FIXED_ROM_DEF ^ 32'h01000000)}, 1'b0, 1'b0, 1'b1, 8'h00);
        give_verdict;
    end
endmodule // pci_bar_config_decode_tb

// ### window_regs.v
// Holds the six programmable base window registers.
// Assumes writes come from the configuration write path on one clock.
`timescale 1ns/1ps

module window_regs
#(
    parameter [191:0] mask_bits = {6{32'hfff00000}}
)
(
    input  wire         clock,
    input  wire         sys_rst,
    input  wire         wr_en,
    input  wire [2:0]   wr_idx,
    input  wire [31:0]  wr_data,
    input  wire [3:0]   wr_be,
    input  wire [2:0]   rd_idx,
    output reg  [31:0]  rd_data_ff,
    output wire [191:0] all_ff
);

    reg [31:0] mem_ff [0:5];
    reg [31:0] merged;
    integer    i;
    integer    j;

    // ****************************************************************
    // Byte-lane writes through per-window mask
    // ****************************************************************
    always @*
    begin
        merged = mem_ff[wr_idx];
        for (i = 0; i < 4; i = i + 1)
            if (wr_be[i])
                merged[i*8 +: 8] = wr_data[i*8 +: 8];
    end

    always @(posedge clock)
    begin
        if (sys_rst)
        begin
            for (j = 0; j < 6; j = j + 1)
                mem_ff[j] <= 32'h00000000;
            rd_data_ff <= 32'h00000000;
        end
        else
        begin
            if (wr_en && wr_idx < 3'h6)
                mem_ff[wr_idx] <= merged & mask_bits[wr_idx*32 +: 32];
            rd_data_ff <= (rd_idx < 3'h6) ? mem_ff[rd_idx] : 32'h00000000;
        end
    end

    genvar g;
    generate
        for (g = 0; g < 6; g = g + 1)
        begin : flat
            assign all_ff[g*32 +: 32] = mem_ff[g];
        end
    endgenerate

endmodule // window_regs
